//--- verilog/wave_ctrl_pkg.sv
// shared constants and types of the waveform output and sleep control block
`default_nettype none
package wave_ctrl_pkg;

    // serial word layout
    localparam int unsigned WORD_BITS = 16;
    localparam logic [3:0] LAST_BIT_COUNT = 4'hF;
    localparam logic [1:0] CMD_CTRL = 2'h0;
    localparam logic [1:0] CMD_FREQ0 = 2'h1;
    localparam logic [1:0] CMD_FREQ1 = 2'h2;
    localparam logic [1:0] CMD_PHASE = 2'h3;
    localparam int unsigned CMD_POS = 14;
    localparam int unsigned PHASE_SEL_POS = 13;

    // register map, word indices and byte addresses on the bus
    localparam logic [5:0] IDX_STATUS = 6'h00;
    localparam logic [5:0] IDX_LAST_WORD = 6'h01;
    localparam logic [5:0] IDX_CONFIG = 6'h02;
    localparam logic [5:0] IDX_PHASE_ACC = 6'h03;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_LAST_WORD = 8'h04;
    localparam logic [7:0] REG_CONFIG = 8'h08;
    localparam logic [7:0] REG_PHASE_ACC = 8'h0C;
    localparam int unsigned STATUS_PENDING_POS = 16;
    localparam int unsigned STATUS_FRAME_IDLE_POS = 17;
    localparam int unsigned FRAME_COUNT_POS = 16;
    localparam int unsigned RX_ENABLE_POS = 0;
    localparam logic RX_ENABLE_RESET = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // dac code levels
    localparam logic [9:0] DAC_MID_LOW = 10'h1FF;
    localparam logic [9:0] DAC_MID_HIGH = 10'h200;

    // first quarter of a sine, 9-bit magnitude above midscale
    localparam logic [8:0] SINE_QUARTER [0:15] = '{
        9'h019, 9'h04B, 9'h07C, 9'h0AC, 9'h0DB, 9'h107, 9'h130, 9'h157,
        9'h17B, 9'h19A, 9'h1B6, 9'h1CE, 9'h1E1, 9'h1F0, 9'h1F9, 9'h1FE
    };

    // control word D15..D0, one field per bit except the two-bit cmd in D15..D14
    typedef struct packed {
        logic [1:0] cmd;
        logic full_freq_write;
        logic upper_half_select;
        logic freq_register_select;
        logic phase_register_select;
        logic reserved_d9;
        logic reserved_d8;
        logic core_clock_sleep_bit;
        logic dac_sleep_bit;
        logic bit_output_enable;
        logic reserved_d4;
        logic msb_divide_select;
        logic reserved_d2;
        logic triangle_mode;
        logic reserved_d0;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = ctrl_t'(16'h0000);

    typedef struct packed {
        logic [1:0] resp;
        logic [31:0] data;
    } axi_read_t;

    // link side state, clocked by the serial clock
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic [3:0] count;
        logic [14:0] shift;
        logic [15:0] word;
        logic toggle;
    } link_state_t;

    // core side state, clocked by the master clock
    typedef struct packed {
        logic tog_s1;
        logic tog_s2;
        logic tog_seen;
        logic fs_s1;
        logic fs_s2;
        logic pending;
        logic [15:0] pend_word;
        logic [15:0] last_word;
        logic [15:0] frame_count;
        logic rx_enable;
        ctrl_t ctrl;
        logic msb_next;
        logic [27:0] freq0;
        logic [27:0] freq1;
        logic [11:0] phase0;
        logic [11:0] phase1;
        logic [27:0] acc;
        logic [11:0] phase_word;
        logic [9:0] dac_code;
        logic msb_half;
        logic bit_out;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } core_state_t;

endpackage
`default_nettype wire

//--- verilog/waveform_output_and_sleep_ctrl.sv
// serial word port, sleep control, oscillator and output select
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none

// Overview of operation
// RQ1: sleep bits power down dac, clock, both
// RQ2: clock sleep freezes oscillator, dac output holds
// RQ3: serial words still stored during clock sleep
// RQ4: select bits still act during clock sleep
// RQ5: waking restarts core, changes follow pipeline
// RQ6: bit output enable routes dac msb out
// RQ7: divide bit picks msb or msb halved
// RQ8: sine table drives dac, divide ignored
// RQ9: triangle mode sends truncated phase to dac
// RQ10: host keeps dac awake for analog output
// RQ11: host serial clock at most 40 MHz
// RQ12: serial clock may run or idle either level
// RQ13: low frame sync frames exactly sixteen bits
// RQ14: data sampled on serial clock falling edge
// RQ15: host sends most significant bit first
// RQ16: two bytes in one frame form one word
// RQ17: top bits 00 write the control register
// RQ18: bit output with triangle mode is reserved
// RQ19: control takes effect after frame sync rises
module waveform_output_and_sleep_ctrl
    import wave_ctrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic link_sclk_in,
    input wire logic frame_sync_n_in,
    input wire logic serial_data_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [9:0] dac_code_out,
    output logic dac_power_down_out,
    output logic core_clock_gated_out,
    output logic bit_output_enable_out,
    output logic waveform_bit_out
);

    // replace one 14-bit half of a frequency register
    function automatic logic [27:0] load_half(
        input logic [27:0] old,
        input logic [13:0] half,
        input logic upper
    );
        return upper ? {half, old[13:0]} : {old[27:14], half};
    endfunction

    // which half of a frequency register the next word fills
    function automatic logic freq_half_upper(
        input ctrl_t c,
        input logic msb_turn
    );
        return c.full_freq_write ? msb_turn : c.upper_half_select;
    endfunction

    // quarter-wave table mirrored into a full 10-bit sine
    function automatic logic [9:0] sine_code(input logic [11:0] ph);
        logic [3:0] idx;
        logic [9:0] mag;
        idx = ph[10] ? ~ph[9:6] : ph[9:6];
        mag = {1'b0, SINE_QUARTER[idx]};
        return ph[11] ? 10'(DAC_MID_LOW - mag) : 10'(DAC_MID_HIGH + mag);
    endfunction

    // truncated phase folded into a 10-bit linear ramp up and down
    function automatic logic [9:0] triangle_code(input logic [11:0] ph);
        return ph[11] ? ~ph[10:1] : ph[10:1];
    endfunction

    // register read decode, unmapped offsets answer with an error
    function automatic axi_read_t read_reg(
        input logic [7:0] addr,
        input core_state_t st
    );
        axi_read_t r;
        r.resp = RESP_OKAY;
        r.data = 32'h0000_0000;
        unique case (addr[7:2])
            IDX_STATUS:
            begin
                r.data[15:0] = st.ctrl;
                r.data[STATUS_PENDING_POS] = st.pending;
                r.data[STATUS_FRAME_IDLE_POS] = st.fs_s2;
            end
            IDX_LAST_WORD:
            begin
                r.data[15:0] = st.last_word;
                r.data[FRAME_COUNT_POS +: 16] = st.frame_count;
            end
            IDX_CONFIG:
            begin
                r.data[RX_ENABLE_POS] = st.rx_enable;
            end
            IDX_PHASE_ACC:
            begin
                r.data[27:0] = st.acc;
            end
            default:
            begin
                r.resp = RESP_SLVERR;
            end
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // link domain: runs only on serial clock falling edges
    // ------------------------------------------------------------------
    link_state_t l;
    link_state_t next_l;

    always_comb
    begin
        next_l = l;
        // rst_s1 feeds only rst_s2; the host must give falls after release
        // because the link clock stands still between frames
        next_l.rst_s1 = rst_n_in;
        next_l.rst_s2 = l.rst_s1;
        if (!l.rst_s2)
        begin
            next_l.count = 4'h0;
            next_l.shift = 15'h0000;
            next_l.word = 16'h0000;
            next_l.toggle = 1'b0;
        end
        else if (frame_sync_n_in)
        begin
            // any fall outside a frame restarts the bit count
            next_l.count = 4'h0; // RQ13
        end
        else if (l.count == LAST_BIT_COUNT)
        begin
            // sixteenth bit completes the word, msb arrived first
            next_l.word = {l.shift, serial_data_in}; // RQ13 RQ14 RQ15 RQ16
            next_l.toggle = ~l.toggle;
            next_l.count = 4'h0;
        end
        else
        begin
            // count carries across an idle gap inside one frame
            next_l.shift = {l.shift[13:0], serial_data_in}; // RQ14 RQ16
            next_l.count = l.count + 4'h1; // RQ12
        end
    end

    // data change on rising edges and are taken on falling ones
    always_ff @(negedge link_sclk_in)
    begin
        l <= next_l; // RQ14
    end

    // ------------------------------------------------------------------
    // core domain on the master clock
    // ------------------------------------------------------------------
    core_state_t s;
    core_state_t next_s;
    ctrl_t w_ctrl;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic [9:0] next_code;
    axi_read_t rd;

    // readies fall while an answer waits: one write and one read at a time
    assign s_axi_awready_out = !s.aw_got && !s.bvalid;
    assign s_axi_wready_out = !s.w_got && !s.bvalid;
    assign s_axi_arready_out = !s.rvalid;
    assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
    assign w_hs = s_axi_wvalid_in && s_axi_wready_out;
    assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;
    assign w_ctrl = ctrl_t'(s.pend_word);

    always_comb
    begin
        next_s = s;
        next_code = s.dac_code;
        rd = read_reg(s_axi_araddr_in, s);

        // crossing: toggle and frame level through two flip-flops each
        next_s.tog_s1 = l.toggle;
        next_s.tog_s2 = s.tog_s1;
        next_s.tog_seen = s.tog_s2;
        next_s.fs_s1 = frame_sync_n_in;
        next_s.fs_s2 = s.fs_s1;

        // decode a held word once the frame has closed
        if (s.pending && s.fs_s2)
        begin
            next_s.pending = 1'b0;
            unique case (s.pend_word[CMD_POS +: 2])
                CMD_CTRL:
                begin
                    next_s.ctrl = w_ctrl; // RQ17 RQ19 RQ3
                    next_s.msb_next = 1'b0;
                end
                CMD_FREQ0, CMD_FREQ1:
                begin
                    if (s.ctrl.full_freq_write)
                    begin
                        next_s.msb_next = ~s.msb_next;
                    end
                    if (s.pend_word[CMD_POS])
                    begin
                        next_s.freq0 = load_half(s.freq0, s.pend_word[13:0],
                            freq_half_upper(s.ctrl, s.msb_next)); // RQ3
                    end
                    else
                    begin
                        next_s.freq1 = load_half(s.freq1, s.pend_word[13:0],
                            freq_half_upper(s.ctrl, s.msb_next)); // RQ3
                    end
                end
                CMD_PHASE:
                begin
                    if (s.pend_word[PHASE_SEL_POS])
                    begin
                        next_s.phase1 = s.pend_word[11:0]; // RQ3
                    end
                    else
                    begin
                        next_s.phase0 = s.pend_word[11:0]; // RQ3
                    end
                end
            endcase
        end

        // a new word arriving wins over the clearing of pending by the decode of the previous one
        // the word has stood since the sixteenth fall and holds until the
        // sixteenth fall of the next frame, so it is safe to read once the toggle has crossed
        if (s.tog_s2 != s.tog_seen && s.rx_enable)
        begin
            next_s.pending = 1'b1;
            next_s.pend_word = l.word; // RQ3
            next_s.last_word = l.word;
            next_s.frame_count = s.frame_count + 16'h0001;
        end

        // oscillator pipeline stands still while the core clock sleeps;
        // frequency words written meanwhile reach the dac three clocks after waking,
        // through the accumulator, phase and code registers; phase words take two
        if (!s.ctrl.core_clock_sleep_bit)
        begin
            next_s.acc = s.acc + (s.ctrl.freq_register_select
                ? s.freq1 : s.freq0); // RQ2 RQ4 RQ5
            next_s.phase_word = s.acc[27:16] + (s.ctrl.phase_register_select
                ? s.phase1 : s.phase0); // RQ4 RQ5
            if (s.ctrl.triangle_mode)
            begin
                next_code = triangle_code(s.phase_word); // RQ9
            end
            else
            begin
                next_code = sine_code(s.phase_word); // RQ8
            end
            next_s.dac_code = next_code; // RQ2 RQ5
            if (next_code[9] && !s.dac_code[9])
            begin
                next_s.msb_half = ~s.msb_half; // RQ7
            end
        end

        // square output only when the bit output is enabled; it follows the
        // new control word at once so the enable and the square agree
        if (next_s.ctrl.bit_output_enable)
        begin
            next_s.bit_out = next_s.ctrl.msb_divide_select
                ? s.dac_code[9] : s.msb_half; // RQ6 RQ7 RQ18
        end
        else
        begin
            next_s.bit_out = 1'b0; // RQ8
        end

        // write channel: address and data accepted in either order
        if (aw_hs)
        begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_axi_awaddr_in;
        end
        if (w_hs)
        begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata_in;
            next_s.wstrb = s_axi_wstrb_in;
        end
        if (s.bvalid && s_axi_bready_in)
        begin
            next_s.bvalid = 1'b0;
        end
        if (next_s.aw_got && next_s.w_got && !s.bvalid)
        begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            unique case (next_s.awaddr[7:2])
                IDX_CONFIG:
                begin
                    if (next_s.wstrb[0])
                    begin
                        next_s.rx_enable = next_s.wdata[RX_ENABLE_POS];
                    end
                end
                // read-only registers answer okay and keep their contents
                IDX_STATUS, IDX_LAST_WORD, IDX_PHASE_ACC:
                begin
                    next_s.bresp = RESP_OKAY;
                end
                default:
                begin
                    next_s.bresp = RESP_SLVERR;
                end
            endcase
        end

        // read channel
        // data are latched at the address handshake and held until rready
        if (s.rvalid && s_axi_rready_in)
        begin
            next_s.rvalid = 1'b0;
        end
        if (ar_hs)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd.data;
            next_s.rresp = rd.resp;
        end

        // synchronous reset last, so it wins over every update above
        if (!rst_n_in)
        begin
            next_s = '0;
            next_s.rx_enable = RX_ENABLE_RESET;
            next_s.ctrl = CTRL_RESET;
            next_s.fs_s1 = 1'b1;
            next_s.fs_s2 = 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        s <= next_s;
    end

    // every output below comes straight from a register
    assign s_axi_bvalid_out = s.bvalid;
    assign s_axi_bresp_out = s.bresp;
    assign s_axi_rvalid_out = s.rvalid;
    assign s_axi_rdata_out = s.rdata;
    assign s_axi_rresp_out = s.rresp;
    assign dac_code_out = s.dac_code; // RQ2
    assign dac_power_down_out = s.ctrl.dac_sleep_bit; // RQ1
    assign core_clock_gated_out = s.ctrl.core_clock_sleep_bit; // RQ1
    assign bit_output_enable_out = s.ctrl.bit_output_enable; // RQ6
    assign waveform_bit_out = s.bit_out; // RQ6

endmodule // waveform_output_and_sleep_ctrl
`default_nettype wire

//--- sim/wave_ctrl_sva.sv
// port assertions of the waveform output and sleep control block
`default_nettype none
module wave_ctrl_sva (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [9:0] dac_code_out,
    input wire logic dac_power_down_out,
    input wire logic core_clock_gated_out,
    input wire logic bit_output_enable_out,
    input wire logic waveform_bit_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_reset_clears_out: assert property ($rose(rst_n_in) |->
        dac_code_out == 10'h000 && !dac_power_down_out && !waveform_bit_out
        && !core_clock_gated_out) else $error("outputs not cleared");
    a_gated_dac_holds: assert property (core_clock_gated_out
        && $past(core_clock_gated_out) |-> $stable(dac_code_out))
        else $error("dac code moved while clock gated");
    a_bit_off_low: assert property (!bit_output_enable_out |->
        !waveform_bit_out) else $error("square out while bit output off");
    a_write_busy: assert property (s_axi_bvalid_out |->
        !s_axi_awready_out && !s_axi_wready_out)
        else $error("write ready during response");
    a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped");
    a_read_busy: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read ready during response");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
        |=> s_axi_rvalid_out) else $error("read answer late");
    a_read_release: assert property (s_axi_rvalid_out && s_axi_rready_in
        |=> !s_axi_rvalid_out) else $error("read answer repeated");
endmodule // wave_ctrl_sva
bind waveform_output_and_sleep_ctrl wave_ctrl_sva wave_ctrl_sva_inst (.*);
`default_nettype wire

//--- sim/serial_host_model.sv
// host side of the framed serial write port
`default_nettype none
module serial_host_model (
    output var logic sclk_out,
    output var logic frame_sync_n_out,
    output var logic data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        sclk_out = 1'b1;
        frame_sync_n_out = 1'b1;
        data_out = 1'b0;
    end
    // falls with frame sync high, only to clear the link logic at reset
    task automatic idle_falls(input int n);
        repeat (n)
        begin
            #31 sclk_out = 1'b0;
            #62.5 sclk_out = 1'b1;
            #31.5;
        end
    endtask
    // one word, msb first, 125 ns clock, optionally in two bytes
    task automatic send_word(input logic [15:0] w, input logic split,
        input logic idle);
        int i;
        sclk_out = idle;
        #20 frame_sync_n_out = 1'b0;
        for (i = 15; i >= 0; i--)
        begin
            data_out = w[i];
            sclk_out = 1'b1;
            #62.5 sclk_out = 1'b0;
            #62.5;
            if (split && i == 8)
            begin
                sclk_out = idle;
                #300;
            end
        end
        sclk_out = idle;
        #20 frame_sync_n_out = 1'b1;
        data_out = ~w[0];
    endtask
endmodule // serial_host_model
`default_nettype wire

//--- sim/test_waveform_output_and_sleep_ctrl.sv
// testbench of the waveform output and sleep control block
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %0t got %h expected %h", $time, (a), (e)); end end
module test_waveform_output_and_sleep_ctrl;
    import wave_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0, rst_n_in = 1'b0;
    wire logic link_sclk_in, frame_sync_n_in, serial_data_in;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
    logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] s_axi_rdata_out;
    logic [9:0] dac_code_out;
    logic dac_power_down_out, core_clock_gated_out;
    logic bit_output_enable_out, waveform_bit_out;
    int miscompares = 0, cmp_count = 0, cycles = 0, md, rs, rs1, i;
    logic [15:0] cnt = 16'h0000, w;
    logic [31:0] seed = 32'h51b0_f7f7;
    axi_read_t exp_q[$];
    axi_read_t e;
    waveform_output_and_sleep_ctrl waveform_output_and_sleep_ctrl_inst (.*);
    serial_host_model serial_host_model_inst (.sclk_out(link_sclk_in),
        .frame_sync_n_out(frame_sync_n_in), .data_out(serial_data_in));
    always #25 clk_in = ~clk_in;
    task automatic give_verdict();
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    // read results are checked against the oldest note
    always @(posedge clk_in)
        if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in === 1'b1)
        begin
            e = exp_q.pop_front();
            `CHK({s_axi_rresp_out, s_axi_rdata_out}, e)
        end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        s_axi_bready_in <= 1'b0;
        `CHK(s_axi_bresp_out, er)
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] r,
        input logic [31:0] d);
        @(posedge clk_in);
        exp_q.push_back('{resp: r, data: d});
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1);
        s_axi_rready_in <= 1'b0;
    endtask
    // one serial word, then enough idle frame sync to decode it
    task automatic tx(input logic [15:0] wd, input logic sp, input logic id);
        serial_host_model_inst.send_word(wd, sp, id);
        cnt++;
        repeat (12) @(posedge clk_in);
    endtask
    // largest dac step and square rising edges over n cycles
    task automatic watch(input int n);
        logic [9:0] p;
        logic b;
        int d;
        md = 0;
        rs = 0;
        @(posedge clk_in);
        p = dac_code_out;
        b = waveform_bit_out;
        repeat (n)
        begin
            @(posedge clk_in);
            d = (dac_code_out > p) ? dac_code_out - p : p - dac_code_out;
            if (d > md) md = d;
            if (waveform_bit_out && !b) rs++;
            p = dac_code_out;
            b = waveform_bit_out;
        end
    endtask
    initial
    begin
        serial_host_model_inst.idle_falls(2);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        // the link side clears its reset only on falls after the release
        serial_host_model_inst.idle_falls(3);
        repeat (4) @(posedge clk_in);
        axi_rd(REG_CONFIG, RESP_OKAY, 32'h0000_0001);
        axi_rd(REG_STATUS, RESP_OKAY, 32'h0002_0000);
        axi_rd(8'h10, RESP_SLVERR, 32'h0000_0000);
        tx(16'h1000, 1'b0, 1'b1);
        tx(16'h4010, 1'b1, 1'b0);
        tx(16'h0008, 1'b0, 1'b0);
        watch(400);
        `CHK(md >= 16 && rs == 0, 1'b1)
        tx(16'h0002, 1'b0, 1'b1);
        watch(400);
        `CHK(md > 0 && md <= 3, 1'b1)
        tx(16'h0028, 1'b1, 1'b1);
        `CHK(bit_output_enable_out, 1'b1)
        watch(4096);
        rs1 = rs;
        tx(16'h0020, 1'b0, 1'b0);
        watch(4096);
        `CHK(rs1 >= 3 && rs >= 1 && 2 * rs <= rs1 + 1, 1'b1)
        for (i = 0; i < 4; i++)
        begin
            w = 16'(i << 6);
            tx(w, i[0], i[1]);
            `CHK({core_clock_gated_out, dac_power_down_out}, i[1:0])
            if (i == 2)
            begin
                watch(50);
                `CHK(md, 0)
                seed = xs(seed);
                w = {CMD_PHASE, seed[13:0]};
                tx(w, seed[14], seed[15]);
                axi_rd(REG_LAST_WORD, RESP_OKAY, {cnt, w});
                tx(16'h0880, 1'b0, 1'b1);
                axi_rd(REG_STATUS, RESP_OKAY, 32'h0002_0880);
            end
        end
        tx(16'h0000, 1'b0, 1'b0);
        watch(50);
        `CHK(md > 0, 1'b1)
        axi_wr(REG_STATUS, 32'h0000_0000, RESP_OKAY);
        axi_wr(8'h20, 32'h0000_0000, RESP_SLVERR);
        axi_wr(REG_CONFIG, 32'h0000_0000, RESP_OKAY);
        axi_rd(REG_CONFIG, RESP_OKAY, 32'h0000_0000);
        tx(16'h0040, 1'b0, 1'b1);
        `CHK(dac_power_down_out, 1'b0)
        axi_wr(REG_CONFIG, 32'h0000_0001, RESP_OKAY);
        tx(16'h0040, 1'b1, 1'b0);
        `CHK(dac_power_down_out, 1'b1)
        give_verdict();
    end
endmodule // test_waveform_output_and_sleep_ctrl
`undef CHK
`default_nettype wire
